// ---- hw/pbr_bridge.v ----
// register window, target write fifo and transfer engine registers behind the pci core
`timescale 1ns/1ps
`include "pbr_regs.vh"
module pbr_bridge #(
  parameter FIFO_AW      = 4,
  parameter DISCARD_CLKS = `PBR_DISCARD_CLKS
)(
  input  wire        clk,
  input  wire        resetn,
  input  wire        pci_addr_vld,
  input  wire        pci_bar0_hit,
  input  wire        pci_bar1_hit,
  input  wire [15:0] pci_addr,
  input  wire        pci_wr,
  input  wire        pci_data_vld,
  input  wire [31:0] pci_wdata,
  input  wire        pci_frame_end,
  output reg  [31:0] pci_rdata,
  output wire        pci_ready,
  output wire        pci_disc,
  output wire        pci_retry,
  output wire        pci_abort,
  output wire        pint_n,
  input  wire        lwe,
  input  wire        lre,
  input  wire [11:0] laddr,
  input  wire [31:0] ldin,
  output reg  [31:0] ldout,
  output wire        lint_n,
  output wire        twf_st,
  output wire [15:0] twf_addr,
  output wire [31:0] twf_dout,
  input  wire        twf_rd,
  input  wire        dma_ok,
  output wire        dma_active,
  output wire        dma_dir,
  output wire [31:0] dma_padr,
  output wire [15:0] dma_ladr,
  output reg         dly_discard
);

  localparam T_IDLE  = 2'h0;
  localparam T_FILL  = 2'h1;
  localparam T_DRAIN = 2'h2;
  localparam FD      = 1 << FIFO_AW;

  reg [31:0] p2l_bell_reg;
  reg [31:0] l2p_bell_reg;
  reg [31:0] p2l_mbox_reg;
  reg [31:0] l2p_mbox_reg;
  reg        p2l_full_reg;
  reg        l2p_full_reg;
  reg [3:0]  lat_set_reg;
  reg [31:0] lat_word_reg;
  reg [15:0] len_reg;
  reg [31:0] padr_reg;
  reg [15:0] ladr_reg;
  reg [31:0] ctrl_reg;
  reg        active_reg;
  reg        b0_sel_reg;
  reg        b0_wr_reg;
  reg [11:0] b0_addr_reg;
  reg [4:0]  wait_reg;
  reg        b1_sel_reg;
  reg        b1_rtry_reg;
  reg        wrap_reg;
  reg [15:0] b1_off_reg;
  reg [15:0] dst_reg;
  reg [1:0]  tstate_reg;
  reg [31:0] mem [0:FD-1];
  reg [FIFO_AW:0] wp_reg;
  reg [FIFO_AW:0] rp_reg;
  reg        pend_reg;
  reg [31:0] disc_cnt_reg;

  wire [4:0]  need;
  wire        b0_go;
  wire        fifo_empty;
  wire        fifo_full;
  wire        b1_act;
  wire        push;
  wire        pop;
  wire        buf_in_ready;
  wire [47:0] buf_out;
  wire        pw;
  wire        lw;
  wire        pr;
  wire        lr;
  wire [31:0] ctrl_view;

  ////////////////////////////////////////////////////////////////////////////////
  // read decode shared by both sides
  function [31:0] rd_mux;
    input [11:0] a;
    input        from_pci;
    begin
      case (a)
        `PBR_OFF_P2L_BELL: rd_mux = p2l_bell_reg;
        `PBR_OFF_L2P_BELL: rd_mux = l2p_bell_reg;
        `PBR_OFF_P2L_MBOX: rd_mux = from_pci ? {32{p2l_full_reg}} : p2l_mbox_reg;
        `PBR_OFF_L2P_MBOX: rd_mux = from_pci ? l2p_mbox_reg : {32{l2p_full_reg}};
        `PBR_OFF_LAT_SET:  rd_mux = from_pci ? {28'h0000000, lat_set_reg} : 32'h00000000;
        `PBR_OFF_LAT_WORD: rd_mux = from_pci ? lat_word_reg : 32'h00000000;
        `PBR_OFF_LEN:      rd_mux = {len_reg, 16'h0000};
        `PBR_OFF_PADR:     rd_mux = padr_reg;
        `PBR_OFF_LADR:     rd_mux = {16'h0000, ladr_reg};
        `PBR_OFF_CTRL:     rd_mux = ctrl_view;
        default:           rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] off;
    input        en;
    begin
      hit = en & (a == off);
    end
  endfunction

  assign ctrl_view = ctrl_reg | ({31'h00000000, p2l_full_reg} << `PBR_CTRL_P2L_FULL)
                   | ({31'h00000000, l2p_full_reg} << `PBR_CTRL_L2P_FULL)
                   | ({31'h00000000, active_reg} << `PBR_CTRL_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////////
  // register window: one data phase, latency set per register
  // the wait count starts at the address phase, so 4 bits keep completion inside 16 clocks
  assign need = (b0_addr_reg == `PBR_OFF_LAT_SET || b0_addr_reg == `PBR_OFF_LAT_WORD)
              ? {1'b0, lat_set_reg} : `PBR_MIN_WAIT;
  assign b0_go = b0_sel_reg & pci_data_vld & (wait_reg >= need);
  assign pw = b0_go & b0_wr_reg;
  assign pr = b0_go & ~b0_wr_reg;
  assign lw = lwe;
  assign lr = lre;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      b0_sel_reg  <= 1'b0;
      b0_wr_reg   <= 1'b0;
      b0_addr_reg <= 12'h000;
      wait_reg    <= 5'h00;
      pci_rdata   <= `PBR_RST_WORD;
      ldout       <= `PBR_RST_WORD;
    end
    else
    begin
      if (pci_addr_vld)
      begin
        b0_sel_reg  <= pci_bar0_hit;
        b0_wr_reg   <= pci_wr;
        b0_addr_reg <= {pci_addr[11:2], 2'h0};
        wait_reg    <= 5'h00;
      end
      else
      begin
        if (b0_go)
          b0_sel_reg <= 1'b0;
        if (wait_reg != `PBR_LAT_CAP)
          wait_reg <= wait_reg + 5'h01;
      end
      pci_rdata <= rd_mux(pci_addr_vld ? {pci_addr[11:2], 2'h0} : b0_addr_reg, 1'b1);
      if (lr)
        ldout <= rd_mux(laddr, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bells, boxes, latency and control registers; pci wins a same-cycle control write
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      p2l_bell_reg <= `PBR_RST_WORD;
      l2p_bell_reg <= `PBR_RST_WORD;
      p2l_mbox_reg <= `PBR_RST_WORD;
      l2p_mbox_reg <= `PBR_RST_WORD;
      p2l_full_reg <= 1'b0;
      l2p_full_reg <= 1'b0;
      lat_set_reg  <= 4'h0;
      lat_word_reg <= `PBR_RST_WORD;
      ctrl_reg     <= `PBR_RST_WORD;
    end
    else
    begin
      // set beats clear: a new bell bit arriving with a clear survives
      p2l_bell_reg <= (p2l_bell_reg & ~(hit(laddr, `PBR_OFF_P2L_BELL, lw) ? ldin : 32'h00000000))
                    | (hit(b0_addr_reg, `PBR_OFF_P2L_BELL, pw) ? pci_wdata : 32'h00000000);
      l2p_bell_reg <= (l2p_bell_reg & ~(hit(b0_addr_reg, `PBR_OFF_L2P_BELL, pw) ? pci_wdata : 32'h00000000))
                    | (hit(laddr, `PBR_OFF_L2P_BELL, lw) ? ldin : 32'h00000000);
      if (hit(b0_addr_reg, `PBR_OFF_P2L_MBOX, pw) && !p2l_full_reg)
      begin
        p2l_mbox_reg <= pci_wdata;
        p2l_full_reg <= 1'b1;
      end
      else if (hit(laddr, `PBR_OFF_P2L_MBOX, lr))
        p2l_full_reg <= 1'b0;
      if (hit(laddr, `PBR_OFF_L2P_MBOX, lw) && !l2p_full_reg)
      begin
        l2p_mbox_reg <= ldin;
        l2p_full_reg <= 1'b1;
      end
      else if (hit(b0_addr_reg, `PBR_OFF_L2P_MBOX, pr))
        l2p_full_reg <= 1'b0;
      if (hit(b0_addr_reg, `PBR_OFF_LAT_SET, pw))
        lat_set_reg <= pci_wdata[`PBR_LAT_BITS-1:0];
      if (hit(b0_addr_reg, `PBR_OFF_LAT_WORD, pw))
        lat_word_reg <= pci_wdata;
      if (hit(b0_addr_reg, `PBR_OFF_CTRL, pw))
        ctrl_reg <= pci_wdata & `PBR_CTRL_WMASK;
      else if (hit(laddr, `PBR_OFF_CTRL, lw))
        ctrl_reg <= ldin & `PBR_CTRL_WMASK;
      else
        ctrl_reg[`PBR_CTRL_START] <= 1'b0;
    end
  end

  // interrupts: only enabled sources reach the recipient side
  assign lint_n = ~((|p2l_bell_reg & ctrl_reg[`PBR_CTRL_P2L_BELL_EN])
                  | (p2l_full_reg & ctrl_reg[`PBR_CTRL_P2L_MBOX_EN]));
  assign pint_n = ~((|l2p_bell_reg & ctrl_reg[`PBR_CTRL_L2P_BELL_EN])
                  | (l2p_full_reg & ctrl_reg[`PBR_CTRL_L2P_MBOX_EN]));

  ////////////////////////////////////////////////////////////////////////////////
  // transfer engine registers
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      len_reg    <= 16'h0000;
      padr_reg   <= `PBR_RST_WORD;
      ladr_reg   <= 16'h0000;
      active_reg <= 1'b0;
    end
    else if (active_reg)
    begin
      // writes are ignored here so a running block cannot be corrupted
      if (dma_ok)
      begin
        len_reg  <= len_reg - 16'h0001;
        padr_reg <= padr_reg + `PBR_XFER_STEP;
        ladr_reg <= ladr_reg + `PBR_LADR_STEP;
        if (len_reg == 16'h0001)
          active_reg <= 1'b0;
      end
    end
    else
    begin
      if (hit(b0_addr_reg, `PBR_OFF_LEN, pw))
        len_reg <= pci_wdata[31:16];
      else if (hit(laddr, `PBR_OFF_LEN, lw))
        len_reg <= ldin[31:16];
      if (hit(b0_addr_reg, `PBR_OFF_PADR, pw))
        padr_reg <= pci_wdata;
      else if (hit(laddr, `PBR_OFF_PADR, lw))
        padr_reg <= ldin;
      if (hit(b0_addr_reg, `PBR_OFF_LADR, pw))
        ladr_reg <= pci_wdata[15:0];
      else if (hit(laddr, `PBR_OFF_LADR, lw))
        ladr_reg <= ldin[15:0];
      if (ctrl_reg[`PBR_CTRL_START] && len_reg != 16'h0000)
        active_reg <= 1'b1;
    end
  end

  assign dma_active = active_reg;
  assign dma_dir    = ctrl_reg[`PBR_CTRL_DIR];
  assign dma_padr   = padr_reg;
  assign dma_ladr   = ladr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // fifo window: posted writes, retry while busy, abort on wrap
  assign fifo_empty = (wp_reg == rp_reg);
  assign fifo_full  = (wp_reg[FIFO_AW-1:0] == rp_reg[FIFO_AW-1:0]) && (wp_reg[FIFO_AW] != rp_reg[FIFO_AW]);
  assign b1_act     = b1_sel_reg & pci_data_vld;
  assign pci_abort  = b1_act & ~b1_rtry_reg & wrap_reg;
  assign push       = b1_act & ~b1_rtry_reg & ~wrap_reg & ~fifo_full;
  assign pci_retry  = b1_act & b1_rtry_reg;
  assign pci_ready  = b0_go | push;
  assign pci_disc   = b0_go | (b1_act & ~b1_rtry_reg & ~wrap_reg & fifo_full);
  assign pop        = (tstate_reg == T_DRAIN) & ~fifo_empty & buf_in_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wp_reg[FIFO_AW-1:0]] <= pci_wdata;
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      tstate_reg  <= T_IDLE;
      b1_sel_reg  <= 1'b0;
      b1_rtry_reg <= 1'b0;
      wrap_reg    <= 1'b0;
      b1_off_reg  <= 16'h0000;
      dst_reg     <= 16'h0000;
      wp_reg      <= {(FIFO_AW+1){1'b0}};
      rp_reg      <= {(FIFO_AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (pci_addr_vld)
      begin
        b1_sel_reg <= pci_bar1_hit;
        wrap_reg   <= 1'b0;
        b1_off_reg <= pci_addr;
        // reads go to the delayed path; writes need an idle, empty fifo
        b1_rtry_reg <= ~pci_wr | (tstate_reg != T_IDLE) | ~fifo_empty;
        if (pci_bar1_hit && pci_wr && tstate_reg == T_IDLE && fifo_empty)
        begin
          tstate_reg <= T_FILL;
          dst_reg    <= pci_addr;
        end
      end
      else
      begin
        if (push)
        begin
          b1_off_reg <= b1_off_reg + 16'h0004;
          if (b1_off_reg == `PBR_B1_LAST)
            wrap_reg <= 1'b1;
        end
        if (pci_frame_end)
          b1_sel_reg <= 1'b0;
      end
      case (tstate_reg)
        T_IDLE:  ;
        T_FILL:
        begin
          if (pci_frame_end)
            tstate_reg <= T_DRAIN;
        end
        T_DRAIN:
        begin
          if (fifo_empty && !twf_st)
            tstate_reg <= T_IDLE;
        end
        default: tstate_reg <= T_IDLE;
      endcase
    end
  end

  // the buffer absorbs a stall by the local side without losing a word
  pbr_skid2 #(
    .DW (48)
  ) u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (pop),
    .in_ready  (buf_in_ready),
    .in_data   ({dst_reg, mem[rp_reg[FIFO_AW-1:0]]}),
    .out_valid (twf_st),
    .out_ready (twf_rd),
    .out_data  (buf_out)
  );

  assign twf_addr = buf_out[47:32];
  assign twf_dout = buf_out[31:0];

  ////////////////////////////////////////////////////////////////////////////////
  // discard timer for a retried read that never comes back
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      pend_reg     <= 1'b0;
      disc_cnt_reg <= 32'h00000000;
      dly_discard  <= 1'b0;
    end
    else
    begin
      dly_discard <= 1'b0;
      if (pci_addr_vld && pci_bar1_hit && !pci_wr)
      begin
        pend_reg     <= 1'b1;
        disc_cnt_reg <= 32'h00000000;
      end
      else if (pend_reg)
      begin
        if (disc_cnt_reg == DISCARD_CLKS - 1)
        begin
          pend_reg    <= 1'b0;
          dly_discard <= 1'b1;
        end
        else
          disc_cnt_reg <= disc_cnt_reg + 32'h00000001;
      end
    end
  end

endmodule

// ---- hw/pbr_regs.vh ----
// register offsets, field positions, reset values and timing counts of the bridge back end
//
// Behaviour
// - register window decodes 4 KB, single phase
// - register accesses end disconnect with data
// - pci bell set raises local interrupt
// - recipient clears bell bit by writing one
// - requester cannot clear bells; mirror for local
// - bell interrupts only when enables set
// - empty box write stores, sets full
// - requester read of box returns full flag
// - recipient read clears full, keeps data
// - full flags in control; box interrupt
// - latency registers complete within 16 clocks
// - latency setting four bits, sets wait
// - latency registers pci only, local zeros
// - length high half 16-bit down-counter
// - pci address increments per transfer
// - local address low half, increments
// - engine registers readable from both sides
// - engine registers locked while engine active
// - fifo window 64 KB, bursts allowed
// - burst past window end gets abort
// - posted write fills fifo, disconnect full
// - drain fifo to latched local address
// - write while fifo busy gets retry
// - delayed completion discarded after timeout
`ifndef PBR_REGS_VH
`define PBR_REGS_VH
`define PBR_BAR0_AW        12
`define PBR_BAR1_AW        16
`define PBR_OFF_P2L_BELL   12'h000
`define PBR_OFF_L2P_BELL   12'h004
`define PBR_OFF_P2L_MBOX   12'h010
`define PBR_OFF_L2P_MBOX   12'h014
`define PBR_OFF_LAT_SET    12'h020
`define PBR_OFF_LAT_WORD   12'h024
`define PBR_OFF_LEN        12'h030
`define PBR_OFF_PADR       12'h034
`define PBR_OFF_LADR       12'h038
`define PBR_OFF_CTRL       12'h03C
`define PBR_CTRL_P2L_BELL_EN 0
`define PBR_CTRL_L2P_BELL_EN 1
`define PBR_CTRL_P2L_MBOX_EN 2
`define PBR_CTRL_L2P_MBOX_EN 3
`define PBR_CTRL_P2L_FULL    4
`define PBR_CTRL_L2P_FULL    5
`define PBR_CTRL_START       8
`define PBR_CTRL_DIR         9
`define PBR_CTRL_ACTIVE      10
`define PBR_CTRL_WMASK     32'h0000030F
`define PBR_RST_WORD       32'h00000000
`define PBR_LAT_BITS       4
`define PBR_MIN_WAIT       5'h01
`define PBR_LAT_CAP        5'h10
`define PBR_XFER_STEP      32'h00000004
`define PBR_LADR_STEP      16'h0004
`define PBR_B1_LAST        16'hFFFC
`define PBR_CLK_NS         10
`define PBR_DISCARD_NS     327680
`define PBR_DISCARD_CLKS   (`PBR_DISCARD_NS / `PBR_CLK_NS)
`endif

// ---- hw/pbr_skid2.v ----
// two-entry buffer between the write fifo and the local side
`timescale 1ns/1ps
module pbr_skid2 #(
  parameter DW = 48
)(
  input  wire          clk,
  input  wire          resetn,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [DW-1:0] in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [DW-1:0] out_data
);

  reg [DW-1:0] e0_reg;
  reg [DW-1:0] e1_reg;
  reg [1:0]    cnt_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = e0_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // entry 0 is always the head; entry 1 shifts down on a pop
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= 2'h0;
      e0_reg  <= {DW{1'b0}};
      e1_reg  <= {DW{1'b0}};
    end
    else
    begin
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      if (pop)
      begin
        if (cnt_reg == 2'h2)
          e0_reg <= e1_reg;
        else if (push)
          e0_reg <= in_data;
        if (push)
          e1_reg <= in_data;
      end
      else if (push)
      begin
        if (cnt_reg == 2'h0)
          e0_reg <= in_data;
        else
          e1_reg <= in_data;
      end
    end
  end

endmodule

// ---- dv/pbr_bridge_assertions.sv ----
// concurrent checks on the bridge ports
`timescale 1ns/1ps
module pbr_bridge_chk (
  input wire        clk,
  input wire        resetn,
  input wire        pci_addr_vld,
  input wire        pci_bar0_hit,
  input wire        pci_ready,
  input wire        pci_disc,
  input wire        lwe,
  input wire        lre,
  input wire        lint_n,
  input wire        pint_n,
  input wire        twf_st,
  input wire        twf_rd,
  input wire [15:0] twf_addr,
  input wire [31:0] twf_dout,
  input wire        dma_ok,
  input wire        dma_active,
  input wire [31:0] dma_padr,
  input wire [15:0] dma_ladr,
  input wire        dly_discard
);
  // tracks an open register window access so fifo data phases are not mixed in
  reg w0_reg;
  always @(posedge clk)
  begin
    if (!resetn)
      w0_reg <= 1'b0;
    else if (pci_addr_vld)
      w0_reg <= pci_bar0_hit;
    else if (pci_ready)
      w0_reg <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_w0_open;
    pci_addr_vld && pci_bar0_hit;
  endsequence
  sequence s_w0_done;
    w0_reg && pci_ready;
  endsequence
  w0_disc_a: assert property (s_w0_done |-> pci_disc)
    else $error("register access ended without disconnect");
  single_phase_a: assert property (s_w0_done |=> !pci_ready)
    else $error("second data phase in register window");
  lat_bound_a: assert property (s_w0_open |-> ##[1:16] pci_ready)
    else $error("register access not done in 16 clocks");
  lint_cause_a: assert property ($fell(lint_n) |-> $past(pci_ready) || $past(lwe))
    else $error("local interrupt without a write");
  pint_cause_a: assert property ($fell(pint_n) |-> $past(lwe) || $past(pci_ready))
    else $error("pci interrupt without a write");
  lint_clear_a: assert property ($rose(lint_n) |-> $past(lwe) || $past(lre) || $past(pci_ready))
    else $error("local interrupt cleared without access");
  active_end_a: assert property ($fell(dma_active) |-> $past(dma_ok))
    else $error("engine stopped without a transfer");
  addr_step_a: assert property (dma_active && dma_ok |=>
    dma_padr == $past(dma_padr) + 32'h4 && dma_ladr == $past(dma_ladr) + 16'h4)
    else $error("engine addresses did not step by four");
  addr_lock_a: assert property (dma_active && !dma_ok |=> $stable(dma_padr) && $stable(dma_ladr))
    else $error("engine address changed while active");
  drain_hold_a: assert property (twf_st && !twf_rd |=> twf_st && $stable(twf_dout) && $stable(twf_addr))
    else $error("drain word lost under stall");
  discard_pulse_a: assert property (dly_discard |=> !dly_discard)
    else $error("discard longer than one clock");
endmodule
bind pbr_bridge pbr_bridge_chk u_chk (.clk, .resetn, .pci_addr_vld, .pci_bar0_hit, .pci_ready, .pci_disc,
  .lwe, .lre, .lint_n, .pint_n, .twf_st, .twf_rd, .twf_addr, .twf_dout, .dma_ok, .dma_active, .dma_padr,
  .dma_ladr, .dly_discard);

// ---- dv/pbr_pci_agent.sv ----
// pci side agent model that issues register and fifo window transactions
`timescale 1ns/1ps
module pbr_pci_agent (
  input  wire        clk,
  input  wire        pci_ready,
  input  wire        pci_disc,
  input  wire        pci_retry,
  input  wire        pci_abort,
  input  wire [31:0] pci_rdata,
  output reg         pci_addr_vld,
  output reg         pci_bar0_hit,
  output reg         pci_bar1_hit,
  output reg  [15:0] pci_addr,
  output reg         pci_wr,
  output reg         pci_data_vld,
  output reg  [31:0] pci_wdata,
  output reg         pci_frame_end
);
  initial
  begin
    {pci_addr_vld, pci_bar0_hit, pci_bar1_hit, pci_wr, pci_data_vld, pci_frame_end} = 6'h00;
    pci_addr = 16'h0000;
    pci_wdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released data lines carry the inverse so stale data cannot pass as valid
  task fin;
  begin
    pci_data_vld <= 1'b0;
    pci_wdata <= ~pci_wdata;
    pci_frame_end <= 1'b1;
    @(posedge clk);
    pci_frame_end <= 1'b0;
  end
  endtask
  // one data phase only in the register window
  task reg_acc(input w, input [11:0] a, input [31:0] d, output [31:0] q, output integer lat);
  begin
    @(posedge clk);
    {pci_addr_vld, pci_bar0_hit, pci_wr} <= {2'h3, w};
    pci_addr <= {4'h0, a};
    @(posedge clk);
    {pci_addr_vld, pci_bar0_hit, pci_data_vld} <= 3'h1;
    pci_wdata <= d;
    lat = 1;
    @(negedge clk);
    while (!pci_ready && lat < 20)
    begin
      @(negedge clk);
      lat = lat + 1;
    end
    q = pci_rdata;
    @(posedge clk);
    fin;
  end
  endtask
  // fifo window burst; tc holds abort, retry, disconnect of the last phase
  task burst(input w, input [15:0] a, input integer n, input [31:0] b, output integer acc, output [2:0] tc);
    integer i;
  begin
    acc = 0;
    tc = 3'h0;
    i = 0;
    @(posedge clk);
    {pci_addr_vld, pci_bar1_hit, pci_wr} <= {2'h3, w};
    pci_addr <= a;
    @(posedge clk);
    {pci_addr_vld, pci_bar1_hit, pci_data_vld} <= 3'h1;
    pci_wdata <= b;
    while (i < 40 && acc < n && tc == 3'h0)
    begin
      @(negedge clk);
      i = i + 1;
      if (pci_ready)
        acc = acc + 1;
      tc = {pci_abort, pci_retry, pci_disc};
      @(posedge clk);
      if (acc < n && tc == 3'h0)
        pci_wdata <= b + acc;
    end
    fin;
  end
  endtask
endmodule

// ---- dv/pbr_bridge_tb_top.sv ----
// self-checking bench for the bridge back end
`timescale 1ns/1ps
`include "pbr_regs.vh"
module pbr_bridge_tb_top;
  reg         clk, resetn, lwe, lre, twf_rd, dma_ok;
  reg  [11:0] laddr;
  reg  [31:0] ldin, q;
  reg  [2:0]  tc;
  integer     n_fail, check_count, lt, acc, i;
  wire        pci_addr_vld, pci_bar0_hit, pci_bar1_hit, pci_wr, pci_data_vld, pci_frame_end;
  wire [15:0] pci_addr, twf_addr, dma_ladr;
  wire [31:0] pci_wdata, pci_rdata, ldout, twf_dout, dma_padr;
  wire        pci_ready, pci_disc, pci_retry, pci_abort, pint_n, lint_n, twf_st, dma_active, dma_dir, dly_discard;
  // short discard count keeps the timeout case inside the run
  pbr_bridge #(.DISCARD_CLKS(16)) DUT (.clk, .resetn, .pci_addr_vld, .pci_bar0_hit, .pci_bar1_hit, .pci_addr,
    .pci_wr, .pci_data_vld, .pci_wdata, .pci_frame_end, .pci_rdata, .pci_ready, .pci_disc, .pci_retry,
    .pci_abort, .pint_n, .lwe, .lre, .laddr, .ldin, .ldout, .lint_n, .twf_st, .twf_addr, .twf_dout, .twf_rd,
    .dma_ok, .dma_active, .dma_dir, .dma_padr, .dma_ladr, .dly_discard);
  pbr_pci_agent u_pci (.clk, .pci_ready, .pci_disc, .pci_retry, .pci_abort, .pci_rdata, .pci_addr_vld,
    .pci_bar0_hit, .pci_bar1_hit, .pci_addr, .pci_wr, .pci_data_vld, .pci_wdata, .pci_frame_end);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task ck(input [31:0] e, input [31:0] s, input [8*12:1] n);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      $display("[ERR] %0s expected %h seen %h", n, e, s);
      n_fail = n_fail + 1;
    end
  end
  endtask
  task rw(input w, input [11:0] a, input [31:0] d);
    u_pci.reg_acc(w, a, d, q, lt);
  endtask
  task la(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge clk);
    {lwe, lre} <= {w, !w};
    laddr <= a;
    ldin <= d;
    @(posedge clk);
    {lwe, lre} <= 2'h0;
    @(negedge clk);
    q = ldout;
  end
  endtask
  task rst;
  begin
    @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    la(0, `PBR_OFF_P2L_BELL, 0);
    ck(32'h0, q, "bell rst");
  end
  endtask
  // drain with the local side stalling every other clock
  task drain(input integer n, input [31:0] b, input [15:0] a);
  begin
    lt = 0;
    i = 0;
    while (i < n && lt < 200)
    begin
      @(negedge clk);
      lt = lt + 1;
      if (twf_st && twf_rd)
      begin
        ck(b + i, twf_dout, "drain data");
        ck({16'h0, a}, {16'h0, twf_addr}, "drain adr");
        i = i + 1;
      end
      @(posedge clk);
      twf_rd <= lt[0];
    end
    ck(n, i, "drain n");
    repeat (3) @(posedge clk) twf_rd <= 1'b0;
    ck(0, twf_st, "empty");
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_bell;
  begin
    rw(1, `PBR_OFF_CTRL, 32'h3);
    rw(1, `PBR_OFF_P2L_BELL, 32'h5);
    ck(0, lint_n, "lint set");
    la(0, `PBR_OFF_P2L_BELL, 0);
    ck(32'h5, q, "p2l bell");
    rw(1, `PBR_OFF_P2L_BELL, 32'h1);
    rw(0, `PBR_OFF_P2L_BELL, 0);
    ck(32'h5, q, "pci no clr");
    la(1, `PBR_OFF_P2L_BELL, 32'h1);
    la(0, `PBR_OFF_P2L_BELL, 0);
    ck(32'h4, q, "bell clr");
    la(1, `PBR_OFF_P2L_BELL, 32'h4);
    ck(1, lint_n, "lint clr");
    rw(1, `PBR_OFF_CTRL, 0);
    rw(1, `PBR_OFF_P2L_BELL, 32'h2);
    la(1, `PBR_OFF_L2P_BELL, 32'h8);
    ck(1, lint_n, "lint masked");
    ck(1, pint_n, "pint masked");
    rw(1, `PBR_OFF_CTRL, 32'h2);
    ck(0, pint_n, "pint set");
    la(1, `PBR_OFF_L2P_BELL, 32'h8);
    ck(0, pint_n, "loc no clr");
    rw(1, `PBR_OFF_L2P_BELL, 32'h8);
    ck(1, pint_n, "pint clr");
    $display("bell test done");
  end
  endtask
  task t_mbox;
  begin
    rw(1, `PBR_OFF_CTRL, 32'h4);
    rw(1, `PBR_OFF_P2L_MBOX, 32'hA5A50001);
    ck(0, lint_n, "box irq");
    rw(1, `PBR_OFF_P2L_MBOX, 32'h2);
    rw(0, `PBR_OFF_P2L_MBOX, 0);
    ck(32'hFFFFFFFF, q, "box flag");
    la(0, `PBR_OFF_CTRL, 0);
    ck(32'h14, q, "ctrl full");
    repeat (2)
    begin
      la(0, `PBR_OFF_P2L_MBOX, 0);
      ck(32'hA5A50001, q, "box data");
    end
    ck(1, lint_n, "box irq clr");
    rw(0, `PBR_OFF_P2L_MBOX, 0);
    ck(0, q, "box empty");
    la(1, `PBR_OFF_L2P_MBOX, 32'h77);
    rw(0, `PBR_OFF_L2P_MBOX, 0);
    ck(32'h77, q, "l2p data");
    la(0, `PBR_OFF_L2P_MBOX, 0);
    ck(0, q, "l2p flag");
    $display("mailbox test done");
  end
  endtask
  task t_lat;
  begin
    for (acc = 0; acc < 4; acc = acc + 1)
    begin
      rw(1, `PBR_OFF_LAT_SET, 32'hF0 | acc * 5);
      rw(0, `PBR_OFF_LAT_SET, 0);
      ck(acc * 5, q, "lat set");
      ck(acc * 5 + 1, lt, "lat wait");
      rw(1, `PBR_OFF_LAT_WORD, 32'h12345670 + acc);
      rw(0, `PBR_OFF_LAT_WORD, 0);
      ck(32'h12345670 + acc, q, "lat word");
    end
    la(1, `PBR_OFF_LAT_WORD, 0);
    la(0, `PBR_OFF_LAT_WORD, 0);
    ck(0, q, "loc lat wd");
    la(0, `PBR_OFF_LAT_SET, 0);
    ck(0, q, "loc lat set");
    rw(0, `PBR_OFF_LAT_WORD, 0);
    ck(32'h12345673, q, "lat kept");
    la(0, 12'h100, 0);
    ck(0, q, "unmapped");
    $display("latency test done");
  end
  endtask
  task t_dma;
  begin
    rw(1, `PBR_OFF_LEN, 32'h0003FFFF);
    rw(0, `PBR_OFF_LEN, 0);
    ck(32'h00030000, q, "len");
    rw(1, `PBR_OFF_PADR, 32'h1000);
    rw(1, `PBR_OFF_LADR, 32'hABCD0100);
    la(0, `PBR_OFF_LADR, 0);
    ck(32'h100, q, "ladr");
    rw(1, `PBR_OFF_CTRL, 32'h300);
    la(1, `PBR_OFF_PADR, 32'h5555);
    ck(1, dma_active, "active");
    ck(1, dma_dir, "dir");
    rw(1, `PBR_OFF_LEN, 32'h00090000);
    for (acc = 0; acc < 3; acc = acc + 1)
    begin
      @(posedge clk);
      dma_ok <= 1'b1;
      @(posedge clk);
      dma_ok <= 1'b0;
      la(0, `PBR_OFF_PADR, 0);
      ck(32'h1004 + 4 * acc, q, "padr");
      rw(0, `PBR_OFF_LEN, 0);
      ck((2 - acc) << 16, q, "len count");
    end
    ck(0, dma_active, "inactive");
    ck(32'h10C, {16'h0, dma_ladr}, "ladr step");
    $display("engine test done");
  end
  endtask
  task t_fifo;
  begin
    u_pci.burst(1, 16'h0200, 20, 32'hC0000000, acc, tc);
    ck(16, acc, "fill");
    ck(3'h1, tc, "fill disc");
    u_pci.burst(1, 16'h0400, 1, 0, acc, tc);
    ck(3'h2, tc, "busy retry");
    drain(16, 32'hC0000000, 16'h0200);
    u_pci.burst(1, 16'hFFF8, 3, 32'hB0, acc, tc);
    ck(2, acc, "wrap words");
    ck(3'h4, tc, "wrap abort");
    drain(2, 32'hB0, 16'hFFF8);
    u_pci.burst(0, 16'h0000, 1, 0, acc, tc);
    ck(3'h2, tc, "read retry");
    lt = 0;
    while (!dly_discard && lt < 40)
    begin
      @(negedge clk);
      lt = lt + 1;
    end
    ck(1, dly_discard, "discard");
    $display("fifo test done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    {resetn, lwe, lre, twf_rd, dma_ok} = 5'h0;
    laddr = 12'h000;
    ldin = 32'h0;
    n_fail = 0;
    check_count = 0;
    rst;
    t_bell;
    rst;
    t_mbox;
    t_lat;
    t_dma;
    t_fifo;
    summarize;
  end
  // the whole run needs a few hundred clocks
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail = n_fail + 1;
    summarize;
  end
endmodule
